// ==== rmcr_defs.vh ====
// constants for the route and multicast configuration register bank
`ifndef RMCR_DEFS_VH
`define RMCR_DEFS_VH
// ****************************************
// register offsets
// ****************************************
`define RMCR_OFF_DEFAULT_PORT 24'h000078
`define RMCR_OFF_MASK_EDIT 24'h000080
`define RMCR_OFF_ASSOC_SEL 24'h000084
`define RMCR_OFF_ASSOC_OP 24'h000088
`define RMCR_OFF_BLOCK_HEAD 24'h000100
`define RMCR_OFF_LINK_TIMEOUT 24'h000120
`define RMCR_OFF_GEN_CTRL 24'h00013c
`define RMCR_PORT_BLK_BASE 24'h000140
`define RMCR_PORT_BLK_STRIDE 24'h000020
`define RMCR_PORT_BLK_LAST 24'h000320
// ****************************************
// field positions
// ****************************************
`define RMCR_MCMD_LSB 4
`define RMCR_MCMD_MSB 6
`define RMCR_EGRESS_LSB 8
`define RMCR_EGRESS_MSB 15
`define RMCR_MSEL_LSB 16
`define RMCR_MSEL_MSB 31
`define RMCR_ACMD_LSB 5
`define RMCR_ACMD_MSB 6
`define RMCR_ASIZE_BIT 7
`define RMCR_TO_LSB 8
`define RMCR_TO_MSB 31
`define RMCR_DISC_BIT 29
// ****************************************
// commands
// ****************************************
`define RMCR_MCMD_CHECK 3'h0
`define RMCR_MCMD_ADD 3'h1
`define RMCR_MCMD_DEL 3'h2
`define RMCR_MCMD_DEL_ALL 3'h4
`define RMCR_MCMD_ADD_ALL 3'h5
`define RMCR_ACMD_CHECK 2'h0
`define RMCR_ACMD_DEL 2'h1
`define RMCR_ACMD_ADD 2'h3
// ****************************************
// reset values and constants
// ****************************************
`define RMCR_RST_DEFAULT_PORT 8'h00
`define RMCR_RST_TIMEOUT 24'hffffff
`define RMCR_FEATURE_CODE 16'h0009
`define RMCR_NEXT_BLOCK_PTR 16'h0000
`define RMCR_NUM_MASKS 16'h000a
`endif

// ==== rmcr_mask_mem.v ====
// multicast mask storage, one port-enable vector per mask
`timescale 1ns/1ps
`default_nettype none
module rmcr_mask_mem #(
	parameter NUM_MASKS = 10,
	parameter NUM_PORTS = 16,
	parameter AW = 4
) (
	input wire clock,
	input wire rst_n,
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [NUM_PORTS-1:0] wr_data,
	input wire [AW-1:0] rd_addr,
	output reg [NUM_PORTS-1:0] rd_data_q
);
	reg [NUM_PORTS-1:0] mem_q [0:NUM_MASKS-1];
	genvar g;
	generate
		for (g = 0; g < NUM_MASKS; g = g + 1) begin : g_ent
			always @(posedge clock) begin
				if (!rst_n) begin
					mem_q[g] <= {NUM_PORTS{1'b0}};
				end else if (wr_en && wr_addr == g) begin
					mem_q[g] <= wr_data;
				end
			end
		end
	endgenerate
	always @(posedge clock) begin
		if (!rst_n) begin
			rd_data_q <= {NUM_PORTS{1'b0}};
		end else if (rd_addr < NUM_MASKS) begin
			rd_data_q <= mem_q[rd_addr];
		end else begin
			rd_data_q <= {NUM_PORTS{1'b0}};
		end
	end
endmodule // rmcr_mask_mem
`default_nettype wire

// ==== rmcr_assoc_mem.v ====
// association table: one bit per mask and destination identifier
`timescale 1ns/1ps
`default_nettype none
module rmcr_assoc_mem #(
	parameter DEPTH = 5120,
	parameter AW = 13
) (
	input wire clock,
	input wire wr_en,
	input wire [AW-1:0] addr,
	input wire wr_bit,
	output reg rd_bit_q
);
	reg mem_q [0:DEPTH-1];
	always @(posedge clock) begin
		if (wr_en) begin
			mem_q[addr] <= wr_bit;
		end
		rd_bit_q <= mem_q[addr];
	end
endmodule // rmcr_assoc_mem
`default_nettype wire

// ==== rmcr_regs.v ====
// route and multicast configuration register bank
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rmcr_defs.vh"
module rmcr_regs #(
	parameter NUM_PORTS = 16,
	parameter NUM_MASKS = 10,
	parameter MASK_AW = 4,
	parameter ASSOC_AW = 13
) (
	input wire clock,
	input wire rst_n,
	input wire [23:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_q,
	output reg [7:0] default_port_q,
	output reg [23:0] link_timeout_q,
	output reg discovered_q,
	output reg [NUM_PORTS*NUM_MASKS-1:0] mask_vectors_q,
	output reg port_blk_sel_q,
	output reg [3:0] port_blk_index_q,
	output reg [2:0] port_blk_word_q
);
	// ****************************************
	// register state
	// ****************************************
	reg [2:0] mask_cmd_q;
	reg [7:0] egress_port_q;
	reg [15:0] mask_select_q;
	reg port_present_q;
	reg [15:0] assoc_mask_q;
	reg [7:0] assoc_target_id_q;
	reg [7:0] assoc_target_id_msb_q;
	reg [1:0] assoc_cmd_q;
	reg assoc_id_size_q;
	reg assoc_present_q;
	reg mchk_pend_q;
	reg achk_pend_q;
	reg [7:0] mchk_port_q;

	wire wr_dp = reg_wr && reg_addr == `RMCR_OFF_DEFAULT_PORT;
	wire wr_me = reg_wr && reg_addr == `RMCR_OFF_MASK_EDIT;
	wire wr_as = reg_wr && reg_addr == `RMCR_OFF_ASSOC_SEL;
	wire wr_ao = reg_wr && reg_addr == `RMCR_OFF_ASSOC_OP;
	wire wr_to = reg_wr && reg_addr == `RMCR_OFF_LINK_TIMEOUT;
	wire wr_gc = reg_wr && reg_addr == `RMCR_OFF_GEN_CTRL;

	// ****************************************
	// mask editing
	// ****************************************
	wire [2:0] w_mcmd = reg_wdata[`RMCR_MCMD_MSB:`RMCR_MCMD_LSB];
	wire [7:0] w_port = reg_wdata[`RMCR_EGRESS_MSB:`RMCR_EGRESS_LSB];
	wire [15:0] w_msel = reg_wdata[`RMCR_MSEL_MSB:`RMCR_MSEL_LSB];
	wire msel_ok = w_msel < NUM_MASKS;
	wire port_ok = w_port < NUM_PORTS;
	wire [MASK_AW-1:0] w_midx = w_msel[MASK_AW-1:0];
	wire [NUM_PORTS-1:0] cur_vec;
	reg [NUM_PORTS-1:0] new_vec;
	reg mwr_en;
	wire [NUM_PORTS-1:0] port_onehot = {{(NUM_PORTS-1){1'b0}}, 1'b1} << w_port[3:0];

	always @* begin
		new_vec = cur_vec;
		mwr_en = 1'b0;
		if (wr_me && msel_ok) begin
			case (w_mcmd)
				`RMCR_MCMD_ADD: begin
					new_vec = cur_vec | (port_ok ? port_onehot : {NUM_PORTS{1'b0}});
					mwr_en = port_ok;
				end
				`RMCR_MCMD_DEL: begin
					new_vec = cur_vec & ~port_onehot;
					mwr_en = port_ok;
				end
				`RMCR_MCMD_DEL_ALL: begin
					new_vec = {NUM_PORTS{1'b0}};
					mwr_en = 1'b1;
				end
				`RMCR_MCMD_ADD_ALL: begin
					new_vec = {NUM_PORTS{1'b1}};
					mwr_en = 1'b1;
				end
				default: begin
					new_vec = cur_vec;
					mwr_en = 1'b0;
				end
			endcase
		end
	end

	// live vectors kept here so edits read-modify-write in one cycle
	reg [NUM_PORTS-1:0] vec_q [0:NUM_MASKS-1];
	assign cur_vec = msel_ok ? vec_q[w_midx] : {NUM_PORTS{1'b0}};
	genvar g;
	generate
		for (g = 0; g < NUM_MASKS; g = g + 1) begin : g_vec
			always @(posedge clock) begin
				if (!rst_n) begin
					vec_q[g] <= {NUM_PORTS{1'b0}};
				end else if (mwr_en && w_midx == g) begin
					vec_q[g] <= new_vec;
				end
			end
			always @(posedge clock) begin
				if (!rst_n) begin
					mask_vectors_q[g*NUM_PORTS +: NUM_PORTS] <= {NUM_PORTS{1'b0}};
				end else if (mwr_en && w_midx == g) begin
					mask_vectors_q[g*NUM_PORTS +: NUM_PORTS] <= new_vec;
				end
			end
		end
	endgenerate

	wire [NUM_PORTS-1:0] mem_rd;
	rmcr_mask_mem #(
		.NUM_MASKS(NUM_MASKS),
		.NUM_PORTS(NUM_PORTS),
		.AW(MASK_AW)
	) u_mask_mem (
		.clock(clock),
		.rst_n(rst_n),
		.wr_en(mwr_en),
		.wr_addr(w_midx),
		.wr_data(new_vec),
		.rd_addr(msel_ok ? w_midx : {MASK_AW{1'b1}}),
		.rd_data_q(mem_rd)
	);

	always @(posedge clock) begin
		if (!rst_n) begin
			mask_cmd_q <= 3'h0;
			egress_port_q <= 8'h00;
			mask_select_q <= 16'h0000;
			mchk_pend_q <= 1'b0;
			mchk_port_q <= 8'h00;
			port_present_q <= 1'b0;
		end else begin
			mchk_pend_q <= wr_me && w_mcmd == `RMCR_MCMD_CHECK;
			if (wr_me) begin
				mask_cmd_q <= w_mcmd;
				egress_port_q <= w_port;
				mask_select_q <= w_msel;
				mchk_port_q <= w_port;
			end
			if (mchk_pend_q) begin
				port_present_q <= (mchk_port_q < NUM_PORTS) && mem_rd[mchk_port_q[3:0]];
			end
		end
	end

	// ****************************************
	// association table
	// ****************************************
	wire [1:0] w_acmd = reg_wdata[`RMCR_ACMD_MSB:`RMCR_ACMD_LSB];
	wire w_asize = reg_wdata[`RMCR_ASIZE_BIT];
	// large ids fold bit 0 of the msb byte in; small ids use the low byte only
	wire [7:0] a_hi = w_asize ? assoc_target_id_msb_q : 8'h00;
	// mask number times 512 plus the 9-bit id, built without an adder
	wire [ASSOC_AW-1:0] a_addr = {assoc_mask_q[3:0], a_hi[0], assoc_target_id_q};
	wire a_ok = assoc_mask_q < NUM_MASKS && (!w_asize || a_hi[7:1] == 7'h00);
	wire a_wr = wr_ao && a_ok && (w_acmd == `RMCR_ACMD_ADD || w_acmd == `RMCR_ACMD_DEL);
	wire a_rd;
	rmcr_assoc_mem #(
		.DEPTH(NUM_MASKS * 512),
		.AW(ASSOC_AW)
	) u_assoc_mem (
		.clock(clock),
		.wr_en(a_wr),
		.addr(a_addr),
		.wr_bit(w_acmd == `RMCR_ACMD_ADD),
		.rd_bit_q(a_rd)
	);
	reg achk_ok_q;
	always @(posedge clock) begin
		if (!rst_n) begin
			assoc_mask_q <= 16'h0000;
			assoc_target_id_q <= 8'h00;
			assoc_target_id_msb_q <= 8'h00;
			assoc_cmd_q <= 2'h0;
			assoc_id_size_q <= 1'b0;
			assoc_present_q <= 1'b0;
			achk_pend_q <= 1'b0;
			achk_ok_q <= 1'b0;
		end else begin
			if (wr_as) begin
				assoc_mask_q <= reg_wdata[15:0];
				assoc_target_id_q <= reg_wdata[23:16];
				assoc_target_id_msb_q <= reg_wdata[31:24];
			end
			achk_pend_q <= wr_ao && w_acmd == `RMCR_ACMD_CHECK;
			achk_ok_q <= a_ok;
			if (wr_ao) begin
				assoc_cmd_q <= w_acmd;
				assoc_id_size_q <= w_asize;
			end
			if (achk_pend_q) begin
				assoc_present_q <= achk_ok_q && a_rd;
			end
		end
	end

	// ****************************************
	// plain configuration registers
	// ****************************************
	always @(posedge clock) begin
		if (!rst_n) begin
			default_port_q <= `RMCR_RST_DEFAULT_PORT;
			link_timeout_q <= `RMCR_RST_TIMEOUT;
			discovered_q <= 1'b0;
		end else begin
			if (wr_dp) begin
				default_port_q <= reg_wdata[7:0];
			end
			if (wr_to) begin
				link_timeout_q <= reg_wdata[`RMCR_TO_MSB:`RMCR_TO_LSB];
			end
			if (wr_gc) begin
				discovered_q <= reg_wdata[`RMCR_DISC_BIT];
			end
		end
	end

	// ****************************************
	// per-port window decode
	// ****************************************
	wire [23:0] pb_off = reg_addr - `RMCR_PORT_BLK_BASE;
	wire pb_hit = reg_addr >= `RMCR_PORT_BLK_BASE &&
		reg_addr < `RMCR_PORT_BLK_LAST + `RMCR_PORT_BLK_STRIDE;
	always @(posedge clock) begin
		if (!rst_n) begin
			port_blk_sel_q <= 1'b0;
			port_blk_index_q <= 4'h0;
			port_blk_word_q <= 3'h0;
		end else begin
			port_blk_sel_q <= (reg_wr || reg_rd) && pb_hit;
			port_blk_index_q <= pb_off[8:5];
			port_blk_word_q <= pb_off[4:2];
		end
	end

	// ****************************************
	// read data
	// ****************************************
	reg [31:0] rdata_d;
	always @* begin
		rdata_d = 32'h00000000;
		case (reg_addr)
			`RMCR_OFF_DEFAULT_PORT: begin
				rdata_d = {24'h000000, default_port_q};
			end
			`RMCR_OFF_MASK_EDIT: begin
				rdata_d = {mask_select_q, egress_port_q, 1'b0, mask_cmd_q, 3'h0, port_present_q};
			end
			`RMCR_OFF_ASSOC_SEL: begin
				rdata_d = {assoc_target_id_msb_q, assoc_target_id_q, assoc_mask_q};
			end
			`RMCR_OFF_ASSOC_OP: begin
				rdata_d = {24'h000000, assoc_id_size_q, assoc_cmd_q, 4'h0, assoc_present_q};
			end
			`RMCR_OFF_BLOCK_HEAD: begin
				rdata_d = {`RMCR_NEXT_BLOCK_PTR, `RMCR_FEATURE_CODE};
			end
			`RMCR_OFF_LINK_TIMEOUT: begin
				rdata_d = {link_timeout_q, 8'h00};
			end
			`RMCR_OFF_GEN_CTRL: begin
				rdata_d = {2'h0, discovered_q, 29'h00000000};
			end
			default: begin
				rdata_d = 32'h00000000;
			end
		endcase
	end
	always @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata_q <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata_q <= rdata_d;
		end else begin
			reg_rdata_q <= 32'h00000000;
		end
	end
endmodule // rmcr_regs
`default_nettype wire

// ==== rmcr_regs_asserts.sv ====
// assertion checker for the register bank
`timescale 1ns/1ps
`default_nettype none
module rmcr_regs_chk #(
	parameter NUM_PORTS = 16,
	parameter NUM_MASKS = 10
) (
	input wire clock,
	input wire rst_n,
	input wire [23:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata_q,
	input wire [7:0] default_port_q,
	input wire [23:0] link_timeout_q,
	input wire discovered_q,
	input wire [NUM_PORTS*NUM_MASKS-1:0] mask_vectors_q,
	input wire port_blk_sel_q,
	input wire [3:0] port_blk_index_q,
	input wire [2:0] port_blk_word_q
);
	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire [23:0] boff = reg_addr - 24'h000140;
	wire [6:0] bsel = {boff[8:5], reg_addr[4:2]};
	wire inblk = (reg_addr >= 24'h000140) && (reg_addr <= 24'h00033f);
	wire acc = reg_wr || reg_rd;
	wire wd29 = reg_wdata[29];
	AST_RESET_VALUES: assert property ($rose(rst_n) |-> default_port_q == 8'h00
		&& link_timeout_q == 24'hffffff && !discovered_q) else $error("bad reset value");
	AST_DEF_PORT_WR: assert property (reg_wr && reg_addr == 24'h000078
		|=> {24'h0, default_port_q} == ($past(reg_wdata) & 32'h000000ff)) else $error("port");
	AST_TIMEOUT_WR: assert property (reg_wr && reg_addr == 24'h000120
		|=> {link_timeout_q, 8'h0} == ($past(reg_wdata) & 32'hffffff00)) else $error("tmo");
	AST_DISC_WR: assert property (reg_wr && reg_addr == 24'h00013c
		|=> discovered_q == $past(wd29)) else $error("discovered flag");
	AST_HOLD: assert property (!reg_wr |=> $stable(default_port_q)
		&& $stable(link_timeout_q) && $stable(discovered_q)) else $error("config changed");
	AST_HEAD_RD: assert property (reg_rd && reg_addr == 24'h000100
		|=> reg_rdata_q == 32'h00000009) else $error("block header");
	AST_PORT_RD: assert property (reg_rd && reg_addr == 24'h000078
		|=> reg_rdata_q == {24'h0, $past(default_port_q)}) else $error("port readback");
	AST_IDLE_RD: assert property (!reg_rd |=> reg_rdata_q == 32'h0) else $error("rdata");
	AST_BLK_HIT: assert property (acc && inblk |=> port_blk_sel_q
		&& {port_blk_index_q, port_blk_word_q} == $past(bsel)) else $error("port block");
	AST_BLK_MISS: assert property (!(acc && inblk) |=> !port_blk_sel_q) else $error("blk");
	COV_MASK: cover property (reg_wr && reg_addr == 24'h000080);
	COV_ASSOC: cover property (reg_wr && reg_addr == 24'h000088);
	COV_BLK: cover property (reg_rd && inblk);
endmodule // rmcr_regs_chk
bind rmcr_regs rmcr_regs_chk #(.NUM_PORTS(NUM_PORTS), .NUM_MASKS(NUM_MASKS)) i_rmcr_regs_chk (
	.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.default_port_q(default_port_q), .link_timeout_q(link_timeout_q),
	.discovered_q(discovered_q), .mask_vectors_q(mask_vectors_q),
	.port_blk_sel_q(port_blk_sel_q), .port_blk_index_q(port_blk_index_q),
	.port_blk_word_q(port_blk_word_q));
`default_nettype wire

// ==== test_rmcr_regs.sv ====
// self-checking testbench for the register bank
`timescale 1ns/1ps
`default_nettype none
module test_rmcr_regs;
	logic clock, rst_n, reg_wr, reg_rd, discovered_q, port_blk_sel_q, pres;
	logic [23:0] reg_addr, link_timeout_q;
	logic [31:0] reg_wdata, reg_rdata_q, rd_v, seed;
	logic [7:0] default_port_q;
	logic [159:0] mask_vectors_q, mm;
	logic [3:0] port_blk_index_q;
	logic [2:0] port_blk_word_q;
	logic [23:0] ra[5] = '{24'h000078, 24'h000120, 24'h00013c, 24'h000100, 24'h00007c};
	logic [31:0] re[5] = '{32'h0, 32'hffffff00, 32'h0, 32'h00000009, 32'h0};
	logic [31:0] mk[5] = '{32'h000000ff, 32'hffffff00, 32'h20000000, 32'h0, 32'h0};
	logic [2:0] cs[9] = '{3'h1, 3'h0, 3'h2, 3'h0, 3'h5, 3'h0, 3'h4, 3'h0, 3'h3};
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;
	int m;
	rmcr_regs i_rmcr_regs (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.default_port_q(default_port_q), .link_timeout_q(link_timeout_q),
		.discovered_q(discovered_q), .mask_vectors_q(mask_vectors_q),
		.port_blk_sel_q(port_blk_sel_q), .port_blk_index_q(port_blk_index_q),
		.port_blk_word_q(port_blk_word_q));
	// ****************************************
	// helpers
	// ****************************************
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic conclude();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [23:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [23:0] a);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 rd_v = reg_rdata_q;
	endtask
	task automatic mop(input int mi, input int p, input logic [2:0] c);
		wr(24'h000080, {mi[15:0], p[7:0], 1'b0, c, 4'h0});
		if (c == 3'h0) pres = (mi < 10 && p < 16) ? mm[mi*16+p] : 1'b0;
		if (mi < 10 && p < 16 && c == 3'h1) mm[mi*16+p] = 1'b1;
		if (mi < 10 && p < 16 && c == 3'h2) mm[mi*16+p] = 1'b0;
		if (mi < 10 && c == 3'h4) mm[mi*16+:16] = 16'h0;
		if (mi < 10 && c == 3'h5) mm[mi*16+:16] = 16'hffff;
		rd(24'h000080);
		chk(rd_v, {mi[15:0], p[7:0], 1'b0, c, 3'h0, pres});
		for (int k = 0; k < 5; k++) chk(mask_vectors_q[k*32+:32], mm[k*32+:32]);
	endtask
	task automatic aop(input int mi, input logic [7:0] id, input logic [1:0] c,
		input logic sz, input logic e);
		wr(24'h000084, {7'h0, sz, id, mi[15:0]});
		rd(24'h000084);
		chk(rd_v, {7'h0, sz, id, mi[15:0]});
		wr(24'h000088, {24'h0, sz, c, 5'h0});
		rd(24'h000088);
		chk(rd_v, {24'h0, sz, c, 4'h0, e});
	endtask
	task automatic rst_chk();
		chk({24'h0, default_port_q}, 32'h0);
		chk({7'h0, discovered_q, link_timeout_q}, 32'h00ffffff);
		for (int k = 0; k < 5; k++) chk(mask_vectors_q[k*32+:32], 32'h0);
		for (int j = 0; j < 5; j++) begin
			rd(ra[j]);
			chk(rd_v, re[j]);
		end
		for (int j = 0; j < 3; j++) begin
			rd(24'h000080 | {20'h0, j[1:0], 2'h0});
			chk(rd_v, 32'h0);
		end
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			err_total++;
			conclude();
		end
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 24'h0;
		reg_wdata = 32'h0;
		rst_n = 1'b0;
		seed = 32'h30b07d92;
		mm = '0;
		pres = 1'b0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		rst_chk();
		for (int k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			for (int j = 0; j < 5; j++) begin
				wr(ra[j], seed);
				rd(ra[j]);
				chk(rd_v, (seed & mk[j]) | (j == 3 ? 32'h00000009 : 32'h0));
			end
			chk({24'h0, default_port_q}, seed & 32'h000000ff);
			chk({link_timeout_q, 8'h0}, seed & 32'hffffff00);
			chk({31'h0, discovered_q}, {31'h0, seed[29]});
		end
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			m = seed[19:16] % 10;
			for (int j = 0; j < 9; j++) mop(m, (seed[3:0] + j) % 16, cs[j]);
		end
		mop(9, 15, 3'h1);
		mop(9, 15, 3'h0);
		mop(10, 2, 3'h1);
		mop(4, 16, 3'h1);
		mop(0, 0, 3'h7);
		mop(10, 2, 3'h0);
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		mm = '0;
		pres = 1'b0;
		rst_chk();
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			m = seed[19:16] % 10;
			aop(m, seed[7:0], 2'h3, k[0], 1'b0);
			aop(m, seed[7:0], 2'h0, k[0], 1'b1);
			aop(m, seed[7:0], 2'h1, k[0], 1'b1);
			aop(m, seed[7:0], 2'h0, k[0], 1'b0);
		end
		aop(10, 8'h05, 2'h3, 1'b0, 1'b0);
		aop(10, 8'h05, 2'h0, 1'b0, 1'b0);
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			rd(24'h000140 + {13'h0, seed[8:2], 2'h0});
			chk({24'h0, port_blk_sel_q, port_blk_index_q, port_blk_word_q},
				{24'h0, 1'b1, seed[8:2]});
		end
		wr(24'h000320, seed);
		rd(24'h000340);
		chk({31'h0, port_blk_sel_q}, 32'h0);
		conclude();
	end
endmodule // test_rmcr_regs
`default_nettype wire
